// ### hw/uifc_regs.vh
// Register map, field positions and reset values of the interrupt/FIFO control block
`ifndef UIFC_REGS_VH
`define UIFC_REGS_VH

// Byte addresses
`define UIFC_ADDR_IER_DLH    32'h50001004
`define UIFC_ADDR_IIR_FCR    32'h50001008

// Reset values
`define UIFC_RST_IER_DLH     8'h00
`define UIFC_RST_FCR         8'h00

// Enable / divisor high byte fields
`define UIFC_IER_RX_DATA     0
`define UIFC_IER_TX_EMPTY    1
`define UIFC_IER_LINE_STAT   2
`define UIFC_IER_MODEM_STAT  3
`define UIFC_IER_PROG_TX_HOLDING_EMPTY   7

// Control write fields
`define UIFC_FCR_QUEUE_EN    0
`define UIFC_FCR_RX_RESET    1
`define UIFC_FCR_TX_RESET    2
`define UIFC_FCR_DMA_MODE    3
`define UIFC_FCR_TET_LSB     4
`define UIFC_FCR_RT_LSB      6

// Identification read fields
`define UIFC_IIR_FIFO_ON     2'b11
`define UIFC_IIR_FIFO_OFF    2'b00

// Pending interrupt codes
`define UIFC_ID_MODEM        4'h0
`define UIFC_ID_NONE         4'h1
`define UIFC_ID_TX_EMPTY     4'h2
`define UIFC_ID_RX_DATA      4'h4
`define UIFC_ID_LINE_STAT    4'h6
`define UIFC_ID_BUSY         4'h7
`define UIFC_ID_TIMEOUT      4'hc

// FIFO depth and fill levels
`define UIFC_DEPTH           5'h10
`define UIFC_RX_LVL_ONE      5'h01
`define UIFC_RX_LVL_QUARTER  5'h04
`define UIFC_RX_LVL_HALF     5'h08
`define UIFC_RX_LVL_TWO_LESS 5'h0e
`define UIFC_TX_LVL_EMPTY    5'h00
`define UIFC_TX_LVL_TWO      5'h02
`define UIFC_TX_LVL_QUARTER  5'h04
`define UIFC_TX_LVL_HALF     5'h08

`endif

// ### hw/uifc_top.v
// Interrupt enable, interrupt identification and FIFO control of a serial port
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "uifc_regs.vh"

module uifc_top (
   // Clock and reset
   input  wire        clk,
   input  wire        nrst,
   // Register port
   input  wire [31:0] addr,
   input  wire [15:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [15:0] rdata,
   // Line and modem control bits held elsewhere
   input  wire        divisor_access_select,
   input  wire        auto_flow_enable,
   input  wire        rts_request,
   // Core status
   input  wire [4:0]  rx_count,
   input  wire [4:0]  tx_count,
   input  wire        line_status_event,
   input  wire        modem_status_event,
   input  wire        busy_detect,
   input  wire        char_timeout,
   input  wire        tx_write,
   // Received characters from the shift path
   input  wire [7:0]  rx_in_data,
   input  wire        rx_in_valid,
   output reg         rx_in_ready,
   // Received characters toward the receive FIFO
   output reg  [7:0]  rx_out_data,
   output reg         rx_out_valid,
   input  wire        rx_out_ready,
   // Control outputs
   output reg  [7:0]  divisor_high_byte,
   output reg         queue_enable,
   output reg         tx_queue_reset,
   output reg         rx_queue_reset,
   output reg  [3:0]  pending_interrupt_code,
   output reg         irq_pending,
   // Flow control and transfer requests
   output reg         rts_n,
   output reg         dma_rx_req_n,
   output reg         dma_tx_req_n
);

   // Receive fill level selected by the threshold field
   function [4:0] rx_level;
      input [1:0] sel;
      begin
         case (sel)
            2'b00:   rx_level = `UIFC_RX_LVL_ONE;
            2'b01:   rx_level = `UIFC_RX_LVL_QUARTER;
            2'b10:   rx_level = `UIFC_RX_LVL_HALF;
            default: rx_level = `UIFC_RX_LVL_TWO_LESS;
         endcase
      end
   endfunction

   // Transmit empty level selected by the threshold field
   function [4:0] tx_level;
      input [1:0] sel;
      begin
         case (sel)
            2'b00:   tx_level = `UIFC_TX_LVL_EMPTY;
            2'b01:   tx_level = `UIFC_TX_LVL_TWO;
            2'b10:   tx_level = `UIFC_TX_LVL_QUARTER;
            default: tx_level = `UIFC_TX_LVL_HALF;
         endcase
      end
   endfunction

   // Stored control state
   reg  [7:0] ier_dlh_reg;       // Enables and divisor high byte share storage
   reg        dma_mode_reg;
   reg  [1:0] rt_reg;
   reg  [1:0] tet_reg;
   reg        tx_holding_empty_pend_reg;
   reg        tx_holding_empty_cond_reg;
   reg        tx_holding_empty_en_reg;
   reg        rx_req_m1_reg;
   reg        tx_req_m1_reg;
   // Two-entry receive buffer
   reg  [7:0] buf0_reg;
   reg  [7:0] buf1_reg;
   reg  [1:0] cnt_reg;
   reg  [7:0] buf0_next;
   reg  [7:0] buf1_next;
   reg  [1:0] cnt_next;
   reg  [1:0] wpos;

   // Decoded accesses
   wire       sel_ier = (addr == `UIFC_ADDR_IER_DLH);
   wire       sel_iir = (addr == `UIFC_ADDR_IIR_FCR);
   wire       wr_ier  = wr & sel_ier;
   wire       wr_fcr  = wr & sel_iir;
   wire       rd_iir  = rd & sel_iir;
   wire       fifo_en = queue_enable;

   // Queue enable change also flushes both queues, as on a classic port
   wire       en_chg  = wr_fcr & (wdata[`UIFC_FCR_QUEUE_EN] != queue_enable);
   wire       tx_rst  = wr_fcr & (wdata[`UIFC_FCR_TX_RESET] | en_chg);
   wire       rx_rst  = wr_fcr & (wdata[`UIFC_FCR_RX_RESET] | en_chg);

   // Fill levels
   wire [4:0] rx_lvl  = rx_level(rt_reg);
   wire [4:0] tx_lvl  = tx_level(tet_reg);
   wire       rx_hit  = fifo_en ? (rx_count >= rx_lvl)
                                : (rx_count != 5'h00);
   wire       rx_any  = (rx_count != 5'h00);
   wire       tx_empty = (tx_count == 5'h00);
   wire       tx_full  = (tx_count >= `UIFC_DEPTH);
   wire       prog_tx_holding_empty = fifo_en & ier_dlh_reg[`UIFC_IER_PROG_TX_HOLDING_EMPTY];
   wire       tx_holding_empty_cond = prog_tx_holding_empty ? (tx_count <= tx_lvl)
                                    : tx_empty;

   // Gated interrupt sources
   wire       src_ls  = line_status_event & ier_dlh_reg[`UIFC_IER_LINE_STAT];
   wire       src_rda = rx_hit & ier_dlh_reg[`UIFC_IER_RX_DATA];
   wire       src_cto = char_timeout & fifo_en
                        & ier_dlh_reg[`UIFC_IER_RX_DATA];
   wire       src_thr = tx_holding_empty_pend_reg & ier_dlh_reg[`UIFC_IER_TX_EMPTY];
   wire       src_ms  = modem_status_event & ier_dlh_reg[`UIFC_IER_MODEM_STAT];

   // Priority encoder; all sources but the latched transmit empty are live, so a serviced one drops out at once
   reg  [3:0] code;
   always @* begin
      if (src_ls)
         code = `UIFC_ID_LINE_STAT;
      else if (src_rda)
         code = `UIFC_ID_RX_DATA;
      else if (src_cto)
         code = `UIFC_ID_TIMEOUT;
      else if (src_thr)
         code = `UIFC_ID_TX_EMPTY;
      else if (src_ms)
         code = `UIFC_ID_MODEM;
      else if (busy_detect)
         code = `UIFC_ID_BUSY;
      else
         code = `UIFC_ID_NONE;
   end

   // Transmit empty pending: set on entry to the empty condition or on enable
   wire tx_holding_empty_set = (tx_holding_empty_cond & ~tx_holding_empty_cond_reg)
                   | (tx_holding_empty_cond & ier_dlh_reg[`UIFC_IER_TX_EMPTY] & ~tx_holding_empty_en_reg);
   // Serviced by a data write or by reading the code while it names this source
   wire tx_holding_empty_clr = tx_write | (rd_iir & (code == `UIFC_ID_TX_EMPTY));

   // Receive buffer next state; a flush drops both entries
   wire push = rx_in_valid & rx_in_ready;
   wire pop  = rx_out_valid & rx_out_ready;
   always @* begin
      buf0_next = buf0_reg;
      buf1_next = buf1_reg;
      cnt_next  = cnt_reg;
      wpos      = cnt_reg;
      if (pop) begin
         buf0_next = buf1_reg;
         wpos      = cnt_reg - 2'b01;
      end
      if (push) begin
         if (wpos == 2'b00)
            buf0_next = rx_in_data;
         else
            buf1_next = rx_in_data;
      end
      cnt_next = wpos + {1'b0, push};
      if (rx_rst)
         cnt_next = 2'b00;
   end

   // Shared enable / divisor high byte
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ier_dlh_reg <= `UIFC_RST_IER_DLH;
      end else if (wr_ier) begin
         if (divisor_access_select)
            ier_dlh_reg <= wdata[7:0];
         else
            ier_dlh_reg <= {wdata[7], ier_dlh_reg[6:4], wdata[3:0]};
      end
   end

   // FIFO control fields; the two reset bits are never stored
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         queue_enable <= ((`UIFC_RST_FCR & 8'h01) != 8'h00);
         dma_mode_reg <= 1'b0;
         rt_reg       <= 2'b00;
         tet_reg      <= 2'b00;
      end else if (wr_fcr) begin
         queue_enable <= wdata[`UIFC_FCR_QUEUE_EN];
         dma_mode_reg <= wdata[`UIFC_FCR_DMA_MODE];
         rt_reg       <= wdata[`UIFC_FCR_RT_LSB+1:`UIFC_FCR_RT_LSB];
         tet_reg      <= wdata[`UIFC_FCR_TET_LSB+1:`UIFC_FCR_TET_LSB];
      end
   end

   // Queue reset pulses last one cycle, so software never has to clear them
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_queue_reset <= 1'b0;
         rx_queue_reset <= 1'b0;
      end else begin
         tx_queue_reset <= tx_rst;
         rx_queue_reset <= rx_rst;
      end
   end

   // Transmit empty tracking; set wins over clear
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_holding_empty_pend_reg <= 1'b0;
         tx_holding_empty_cond_reg <= 1'b0;
         tx_holding_empty_en_reg   <= 1'b0;
      end else begin
         tx_holding_empty_cond_reg <= tx_holding_empty_cond;
         tx_holding_empty_en_reg   <= ier_dlh_reg[`UIFC_IER_TX_EMPTY];
         if (tx_holding_empty_set)
            tx_holding_empty_pend_reg <= 1'b1;
         else if (tx_holding_empty_clr | ~tx_holding_empty_cond)
            tx_holding_empty_pend_reg <= 1'b0;
      end
   end

   // Identification outputs
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pending_interrupt_code <= `UIFC_ID_NONE;
         irq_pending            <= 1'b0;
      end else begin
         pending_interrupt_code <= code;
         irq_pending            <= (code != `UIFC_ID_NONE);
      end
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 16'h0000;
      end else if (rd & sel_ier) begin
         if (divisor_access_select)
            rdata <= {8'h00, ier_dlh_reg};
         else
            rdata <= {8'h00, ier_dlh_reg[7], 3'b000, ier_dlh_reg[3:0]};
      end else if (rd_iir) begin
         rdata <= {8'h00, (fifo_en ? `UIFC_IIR_FIFO_ON : `UIFC_IIR_FIFO_OFF),
                   2'b00, code};
      end else begin
         rdata <= 16'h0000;                           // Unmapped reads return zero
      end
   end

   // Divisor byte toward the baud generator
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         divisor_high_byte <= `UIFC_RST_IER_DLH;
      else
         divisor_high_byte <= ier_dlh_reg;
   end

   // Flow control: drop request-to-send at the level, raise again below it
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         rts_n <= 1'b1;
      else if (auto_flow_enable & fifo_en)
         rts_n <= ~rts_request | (rx_count >= rx_lvl);
      else
         rts_n <= ~rts_request;
   end

   // Mode 1 request latches: rx holds until drained, tx until full
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_req_m1_reg <= 1'b0;
         tx_req_m1_reg <= 1'b0;
      end else begin
         if (rx_rst | ~rx_any)
            rx_req_m1_reg <= 1'b0;
         else if (rx_hit | (char_timeout & fifo_en))
            rx_req_m1_reg <= 1'b1;
         if (tx_full)
            tx_req_m1_reg <= 1'b0;
         else if (tx_rst | (tx_count <= tx_lvl))
            tx_req_m1_reg <= 1'b1;
      end
   end

   // Transfer requests, active low; mode 0 follows single-character state
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dma_rx_req_n <= 1'b1;
         dma_tx_req_n <= 1'b1;
      end else if (dma_mode_reg & fifo_en) begin
         dma_rx_req_n <= ~rx_req_m1_reg;
         dma_tx_req_n <= ~tx_req_m1_reg;
      end else begin
         dma_rx_req_n <= ~rx_any;
         dma_tx_req_n <= ~tx_empty;
      end
   end

   // Receive buffer storage; ready and valid come from the next count
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         buf0_reg     <= 8'h00;
         buf1_reg     <= 8'h00;
         cnt_reg      <= 2'b00;
         rx_in_ready  <= 1'b0;
         rx_out_valid <= 1'b0;
         rx_out_data  <= 8'h00;
      end else begin
         buf0_reg     <= buf0_next;
         buf1_reg     <= buf1_next;
         cnt_reg      <= cnt_next;
         rx_in_ready  <= (cnt_next != 2'b10);
         rx_out_valid <= (cnt_next != 2'b00);
         rx_out_data  <= buf0_next;
      end
   end

endmodule // uifc_top

`default_nettype wire

// ### dv/uifc_top_props.sv
// Port-level checks of the interrupt and FIFO control block
`timescale 1ns/1ns
`default_nettype none
module uifc_top_props (
   // Clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // Register port
   input wire logic [31:0] addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   // Sources and control inputs
   input wire logic        auto_flow_enable,
   input wire logic        rts_request,
   input wire logic [4:0]  rx_count,
   input wire logic        line_status_event,
   input wire logic        busy_detect,
   // Outputs under check
   input wire logic [7:0]  divisor_high_byte,
   input wire logic        queue_enable,
   input wire logic        tx_queue_reset,
   input wire logic        rx_queue_reset,
   input wire logic [3:0]  pending_interrupt_code,
   input wire logic        rts_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Shared offset decode
   wire ctl_wr = wr && (addr == 32'h50001008);
   wire id_rd  = rd && (addr == 32'h50001008);
   AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data not zero outside read");
   AST_FIFO_STAT: assert property ($past(id_rd) |-> rdata[7:6] == {2{$past(queue_enable)}})
      else $error("fifo status bits wrong");
   AST_ID_MATCH: assert property ($past(id_rd) |-> rdata[3:0] == pending_interrupt_code)
      else $error("read code differs from code output");
   AST_LINE_TOP: assert property ($past(line_status_event) && divisor_high_byte[2]
      |-> pending_interrupt_code == 4'h6)
      else $error("line status not on top");
   AST_ALL_OFF: assert property (divisor_high_byte[3:0] == 4'h0 && !$past(busy_detect)
      |-> pending_interrupt_code == 4'h1)
      else $error("code raised with enables off");
   AST_RTS_LVL: assert property ($past(auto_flow_enable && queue_enable && rx_count >= 5'h0e)
      |-> rts_n)
      else $error("send request kept at level");
   AST_RTS_SW: assert property ($past(!auto_flow_enable) |-> rts_n == !$past(rts_request))
      else $error("send request not following software");
   AST_TX_RST: assert property ($past(ctl_wr && wdata[2]) |-> tx_queue_reset)
      else $error("transmit reset pulse missing");
   AST_QEN: assert property ($past(ctl_wr) |-> queue_enable == $past(wdata[0]))
      else $error("fifo mode not taken");
   AST_RX_RST: assert property ($past(ctl_wr && wdata[1]) |-> rx_queue_reset)
      else $error("receive reset pulse missing");
   AST_RST_SELF: assert property (!$past(ctl_wr) |-> !tx_queue_reset && !rx_queue_reset)
      else $error("queue reset did not clear itself");
endmodule // uifc_top_props
bind uifc_top uifc_top_props u_props (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .auto_flow_enable(auto_flow_enable),
   .rts_request(rts_request), .rx_count(rx_count), .line_status_event(line_status_event),
   .busy_detect(busy_detect), .divisor_high_byte(divisor_high_byte),
   .queue_enable(queue_enable), .tx_queue_reset(tx_queue_reset),
   .rx_queue_reset(rx_queue_reset),
   .pending_interrupt_code(pending_interrupt_code), .rts_n(rts_n));
`default_nettype wire

// ### dv/uifc_far.sv
// Far-side model: receive shift path and a stalling receive FIFO sink
`timescale 1ns/1ns
`default_nettype none
module uifc_far (
   // Clock, reset and bench control
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [3:0] send_cnt,
   input  wire logic       stall,
   // Buffer ports
   output logic      [7:0] rx_in_data,
   output logic            rx_in_valid,
   input  wire logic       rx_in_ready,
   input  wire logic [7:0] rx_out_data,
   input  wire logic       rx_out_valid,
   output logic            rx_out_ready,
   // Progress
   output logic      [3:0] sent,
   output logic      [3:0] got,
   output logic            bad
);
   // Idle data is inverted so a stale byte can never pass as fresh
   assign rx_in_valid  = (sent < send_cnt);
   assign rx_in_data   = rx_in_valid ? {4'ha, sent} : ~{4'ha, sent};
   assign rx_out_ready = !stall;
   // Count pushes, check pops arrive in order
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sent <= 4'h0;
         got  <= 4'h0;
         bad  <= 1'b0;
      end else begin
         if (rx_in_valid && rx_in_ready)
            sent <= sent + 4'h1;
         if (rx_out_valid && rx_out_ready) begin
            got <= got + 4'h1;
            bad <= bad | (rx_out_data !== {4'ha, got});
         end
      end
   end
endmodule // uifc_far
`default_nettype wire

// ### dv/test_uifc_top.sv
// Self-checking bench of the interrupt and FIFO control block
`timescale 1ns/1ns
`default_nettype none
module test_uifc_top;
   localparam logic [31:0] IER = 32'h50001004;
   localparam logic [31:0] INTERRUPT_IDENTIFICATION = 32'h50001008;
   logic        clk, nrst, wr, rd, dsel, afe, rts_req, lse, mse, busy, tmo, txw, stall;
   logic [31:0] addr;
   logic [15:0] wdata;
   logic [4:0]  rxc, txc;
   logic [3:0]  send_cnt;
   wire  [15:0] rdata;
   wire  [7:0]  ind, outd, dhb;
   wire  [3:0]  code, sent, got;
   wire         inv, inr, outv, outr, qen, txr, rxr, irq, rts_n, drx_n, dtx_n, bad;
   int          failures = 0;
   int          checks_done = 0;
   uifc_top u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .divisor_access_select(dsel), .auto_flow_enable(afe),
      .rts_request(rts_req), .rx_count(rxc), .tx_count(txc), .line_status_event(lse),
      .modem_status_event(mse), .busy_detect(busy), .char_timeout(tmo), .tx_write(txw),
      .rx_in_data(ind), .rx_in_valid(inv), .rx_in_ready(inr), .rx_out_data(outd),
      .rx_out_valid(outv), .rx_out_ready(outr), .divisor_high_byte(dhb),
      .queue_enable(qen), .tx_queue_reset(txr), .rx_queue_reset(rxr),
      .pending_interrupt_code(code), .irq_pending(irq), .rts_n(rts_n),
      .dma_rx_req_n(drx_n), .dma_tx_req_n(dtx_n));
   uifc_far u_far (.clk(clk), .nrst(nrst), .send_cnt(send_cnt), .stall(stall),
      .rx_in_data(ind), .rx_in_valid(inv), .rx_in_ready(inr), .rx_out_data(outd),
      .rx_out_valid(outv), .rx_out_ready(outr), .sent(sent), .got(got), .bad(bad));
   // Compare, bus cycles and settled waits
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input string nm, input logic [31:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(nm, rdata, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic t_regs;
      rd_chk("ier_rst", IER, 16'h0000);
      rd_chk("iir_rst", INTERRUPT_IDENTIFICATION, 16'h0001);
      wr_reg(IER, 16'h00ff);
      rd_chk("ier", IER, 16'h008f);
      @(posedge clk) dsel <= 1'b1;
      wr_reg(IER, 16'h00a5);
      rd_chk("dlh", IER, 16'h00a5);
      chk("dlh_out", {8'h00, dhb}, 16'h00a5);
      @(posedge clk) dsel <= 1'b0;
      rd_chk("ier_view", IER, 16'h0085);
      wr_reg(32'h50001000, 16'h00ff);
      rd_chk("unmapped", 32'h50001000, 16'h0000);
      wr_reg(INTERRUPT_IDENTIFICATION, 16'h0007);
      rd_chk("fifo_on", INTERRUPT_IDENTIFICATION, 16'h00c1);
      wr_reg(INTERRUPT_IDENTIFICATION, 16'h0000);
      rd_chk("fifo_off", INTERRUPT_IDENTIFICATION, 16'h0001);
      $display("regs done");
   endtask
   // Source table {line, rx, timeout, modem, busy}, then modem, line and rx enables one at a time, then none
   task automatic t_prio;
      logic [4:0] src [0:6];
      logic [3:0] id [0:6];
      logic [3:0] gid [0:3];
      src = '{5'h10, 5'h1f, 5'h0f, 5'h07, 5'h03, 5'h01, 5'h00};
      id = '{4'h6, 4'h6, 4'h4, 4'hc, 4'h0, 4'h7, 4'h1};
      gid = '{4'h0, 4'h6, 4'h4, 4'h1};
      wr_reg(INTERRUPT_IDENTIFICATION, 16'h0001);
      wr_reg(IER, 16'h000f);
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         {lse, tmo, mse, busy} <= {src[i][4], src[i][2:0]};
         rxc <= {4'h0, src[i][3]};
         tick(2);
         rd_chk("prio", INTERRUPT_IDENTIFICATION, {8'h00, 4'hc, id[i]});
         chk("irq", {15'h0000, irq}, {15'h0000, id[i] != 4'h1});
      end
      @(posedge clk);
      {lse, tmo, mse} <= 3'b111;
      rxc <= 5'h01;
      for (int i = 0; i < 4; i++) begin
         wr_reg(IER, 16'h0008 >> (i == 3 ? 4 : i + i / 2));
         tick(2);
         rd_chk("gate", INTERRUPT_IDENTIFICATION, {8'h00, 4'hc, gid[i]});
      end
      @(posedge clk);
      {lse, tmo, mse} <= 3'b000;
      rxc <= 5'h00;
      $display("prio done");
   endtask
   task automatic t_levels;
      logic [4:0] lvl [0:3];
      lvl = '{5'h01, 5'h04, 5'h08, 5'h0e};
      wr_reg(IER, 16'h0001);
      afe <= 1'b1;
      rts_req <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr_reg(INTERRUPT_IDENTIFICATION, {8'h00, 2'(i), 6'h01});
         rxc <= lvl[i] - 5'h01;
         tick(2);
         rd_chk("below", INTERRUPT_IDENTIFICATION, 16'h00c1);
         chk("rts_below", {15'h0000, rts_n}, 16'h0000);
         @(posedge clk) rxc <= lvl[i];
         tick(2);
         rd_chk("at", INTERRUPT_IDENTIFICATION, 16'h00c4);
         chk("rts_at", {15'h0000, rts_n}, 16'h0001);
      end
      @(posedge clk) afe <= 1'b0;
      $display("levels done");
   endtask
   task automatic t_tx;
      wr_reg(IER, 16'h0002);
      txc <= 5'h00;
      tick(2);
      rd_chk("tx_holding_empty", INTERRUPT_IDENTIFICATION, 16'h00c2);
      rd_chk("tx_holding_empty_read", INTERRUPT_IDENTIFICATION, 16'h00c1);
      @(posedge clk) txc <= 5'h03;
      wr_reg(IER, 16'h0082);
      wr_reg(INTERRUPT_IDENTIFICATION, 16'h0011);
      tick(2);
      rd_chk("tet_above", INTERRUPT_IDENTIFICATION, 16'h00c1);
      @(posedge clk) txc <= 5'h02;
      tick(2);
      rd_chk("tet_at", INTERRUPT_IDENTIFICATION, 16'h00c2);
      @(posedge clk) txw <= 1'b1;
      @(posedge clk) txw <= 1'b0;
      tick(2);
      rd_chk("tx_write", INTERRUPT_IDENTIFICATION, 16'h00c1);
      $display("tx done");
   endtask
   // Mode 0 follows counts; mode 1 latches the receive request past its level
   task automatic t_dma;
      wr_reg(INTERRUPT_IDENTIFICATION, 16'h0001);
      rxc <= 5'h01;
      txc <= 5'h00;
      tick(2);
      chk("dma_m0", {14'h0000, drx_n, dtx_n}, 16'h0000);
      wr_reg(INTERRUPT_IDENTIFICATION, 16'h00cb);
      rxc <= 5'h04;
      txc <= 5'h10;
      tick(3);
      chk("dma_m1", {14'h0000, drx_n, dtx_n}, 16'h0003);
      @(posedge clk) rxc <= 5'h0e;
      tick(3);
      chk("dma_lvl", {15'h0000, drx_n}, 16'h0000);
      @(posedge clk) rxc <= 5'h04;
      tick(3);
      chk("dma_hold", {15'h0000, drx_n}, 16'h0000);
      @(posedge clk) rxc <= 5'h00;
      $display("dma done");
   endtask
   // Sink stalls until the buffer refuses, then drains it empty
   task automatic t_buf;
      @(posedge clk) send_cnt <= 4'h6;
      tick(5);
      chk("full", {11'h000, inr, sent}, 16'h0002);
      @(posedge clk) stall <= 1'b0;
      tick(12);
      chk("drain", {10'h000, outv, bad, got}, 16'h0006);
      $display("buffer done");
   endtask
   task automatic end_of_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      end_of_test;
   end
   // Main sequence
   initial begin
      {nrst, wr, rd, dsel, afe, rts_req, lse, mse, busy, tmo, txw} = '0;
      addr = 32'h00000000;
      wdata = 16'h0000;
      rxc = 5'h00;
      txc = 5'h05;
      send_cnt = 4'h0;
      stall = 1'b1;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_regs;
      t_prio;
      t_levels;
      t_tx;
      t_dma;
      t_buf;
      end_of_test;
   end
endmodule // test_uifc_top
`default_nettype wire
